// ---- src/spm_ctrl.sv ----
`timescale 1ns/1ps
module spm_ctrl
  import spm_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic modeWrite,
  input wire logic [3:0] modeWriteData,
  input wire logic instrRetire,
  input wire logic nmiRequest,
  input wire logic [NSRC-1:0] irqSet,
  input wire logic [NSRC-1:0] irqEnable,
  input wire logic [NSRC*3-1:0] irqLevel,
  input wire logic [NSRC-1:0] flagClear,
  input wire logic irqFlagWriteEnable,
  input wire logic maskableIrqGlobalEnable,
  input wire logic [2:0] interruptMaskLevel,
  output logic [3:0] operatingModeRegister,
  output logic [NSRC-1:0] irqRequest,
  output logic cpuRun,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic systemClockFast,
  output logic watchdogRun,
  output logic settling
);
  spm_wake_if wif();
  spm_state_e state;
  spm_state_e next_state;
  logic [3:0] next_mode;
  logic wasFast;
  logic next_wasFast;
  logic [2:0] pendCount;
  logic [2:0] next_pendCount;
  logic pendDeep;
  logic next_pendDeep;
  logic [31:0] settleCount;
  logic [31:0] next_settleCount;
  logic nmiMeta;
  logic nmiSync;
  logic wakeAny;

  spm_wake_arb u_arb (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .irqSet(irqSet),
    .irqEnable(irqEnable),
    .irqLevel(irqLevel),
    .flagClear(flagClear),
    .irqFlagWriteEnable(irqFlagWriteEnable),
    .maskableIrqGlobalEnable(maskableIrqGlobalEnable),
    .interruptMaskLevel(interruptMaskLevel),
    .irqRequest(irqRequest),
    .w(wif.arb)
  );

  // The non-maskable source may come from a pin, so it is synchronised.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nmiMeta <= 1'b0;
      nmiSync <= 1'b0;
    end else begin
      nmiMeta <= nmiRequest;
      nmiSync <= nmiMeta;
    end
  end

  assign wakeAny = wif.wake | nmiSync;

  always_comb begin
    next_state = state;
    next_mode = operatingModeRegister;
    next_wasFast = wasFast;
    next_pendCount = pendCount;
    next_pendDeep = pendDeep;
    next_settleCount = settleCount;
    case (state)
      SPM_NORMAL: begin
        if (modeWrite) begin
          if (modeWriteData == MODE_SLOW) begin
            next_state = SPM_SLOW; // R13 R14
            next_mode = MODE_SLOW;
          end else if (modeWriteData == MODE_LIGHT || modeWriteData == MODE_DEEP) begin
            next_state = SPM_PEND; // R15 R16
            next_wasFast = 1'b1;
            next_pendDeep = (modeWriteData == MODE_DEEP);
            next_pendCount = HALT_DELAY;
            next_mode = modeWriteData;
          end
        end
      end
      SPM_SLOW: begin
        if (modeWrite) begin
          // A direct request for normal mode is ignored; idle must come first.
          if (modeWriteData == MODE_IDLE) begin // R20
            next_state = SPM_IDLE; // R12
            next_mode = MODE_IDLE;
          end else if (modeWriteData == MODE_LIGHT || modeWriteData == MODE_DEEP) begin
            next_state = SPM_PEND; // R15 R16
            next_wasFast = 1'b0;
            next_pendDeep = (modeWriteData == MODE_DEEP);
            next_pendCount = HALT_DELAY;
            next_mode = modeWriteData;
          end
        end
      end
      SPM_IDLE: begin
        if (modeWrite) begin
          if (modeWriteData == MODE_NORMAL) begin // R20
            next_state = SPM_NORMAL; // R12
            next_mode = MODE_NORMAL;
          end else if (modeWriteData == MODE_SLOW) begin
            next_state = SPM_SLOW;
            next_mode = MODE_SLOW;
          end
        end
      end
      SPM_PEND: begin
        // A few instructions still retire after the standby write.
        if (pendCount == 3'h0) begin
          next_state = pendDeep ? SPM_DEEP : SPM_LIGHT; // R17
        end else if (instrRetire) begin
          next_pendCount = pendCount - 3'h1; // R17
        end
      end
      SPM_LIGHT: begin
        if (wakeAny) begin
          next_state = wasFast ? SPM_NORMAL : SPM_SLOW; // R3 R9 R10
          next_mode = wasFast ? MODE_NORMAL : MODE_SLOW;
        end
      end
      SPM_DEEP: begin
        if (wakeAny) begin
          next_state = SPM_SETTLE; // R5
          next_settleCount = SETTLE_COUNT;
        end
      end
      SPM_SETTLE: begin
        if (settleCount <= 32'h1) begin
          next_state = wasFast ? SPM_NORMAL : SPM_SLOW; // R5 R9 R10
          next_mode = wasFast ? MODE_NORMAL : MODE_SLOW;
        end else begin
          next_settleCount = settleCount - 32'h1;
        end
      end
      default: begin
        next_state = SPM_NORMAL;
        next_mode = MODE_NORMAL;
      end
    endcase
  end

  // Reset goes through the settling wait, like a deep sleep wake.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= SPM_SETTLE; // R8 R9
      operatingModeRegister <= MODE_NORMAL;
      wasFast <= 1'b1;
      pendCount <= 3'h0;
      pendDeep <= 1'b0;
      settleCount <= SETTLE_CYCLES;
    end else begin
      state <= next_state;
      operatingModeRegister <= next_mode;
      wasFast <= next_wasFast;
      pendCount <= next_pendCount;
      pendDeep <= next_pendDeep;
      settleCount <= next_settleCount;
    end
  end

  always_comb begin
    cpuRun = 1'b0;
    fastOscEnable = 1'b1;
    slowOscEnable = 1'b1;
    systemClockFast = 1'b1;
    watchdogRun = 1'b0;
    settling = 1'b0;
    case (state)
      SPM_NORMAL: begin
        cpuRun = 1'b1;
        watchdogRun = 1'b1;
      end
      SPM_PEND: begin
        cpuRun = 1'b1;
        watchdogRun = 1'b1;
        fastOscEnable = wasFast;
        systemClockFast = wasFast;
      end
      SPM_SLOW: begin
        cpuRun = 1'b1; // R6
        watchdogRun = 1'b1;
        fastOscEnable = 1'b0; // R6
        systemClockFast = 1'b0; // R11
      end
      SPM_IDLE: begin
        cpuRun = 1'b1; // R7
        watchdogRun = 1'b1;
        systemClockFast = 1'b0; // R7 R11
      end
      SPM_LIGHT: begin
        fastOscEnable = wasFast; // R1 R2
        systemClockFast = wasFast; // R11
      end
      SPM_DEEP: begin
        fastOscEnable = 1'b0; // R4
        slowOscEnable = 1'b0; // R4
        systemClockFast = wasFast;
      end
      SPM_SETTLE: begin
        settling = 1'b1;
        fastOscEnable = wasFast;
        systemClockFast = wasFast;
      end
      default: begin
        cpuRun = 1'b0;
      end
    endcase
  end
endmodule

// ---- src/spm_pkg.sv ----
// How it works
// [R1] Fast light sleep stops the CPU, both oscillators keep running.
// [R2] Slow light sleep stops the CPU and fast oscillator; slow oscillator runs.
// [R3] Accepted interrupt leaves light sleep back to normal or slow mode.
// [R4] Deep sleep halts the CPU and both oscillators.
// [R5] Deep sleep wake restarts oscillators, waits for settling, then resumes.
// [R6] Slow mode runs from the slow clock with the fast oscillator off.
// [R7] Idle mode runs the CPU on the slow clock while the fast oscillator settles.
// [R8] Reset and interrupts both wake from standby; reset is a full reset.
// [R9] Settling wait after reset and deep sleep wake, none after light sleep.
// [R10] Wake restores the fast or slow selection active before standby.
// [R11] System clock is fast in normal and fast light sleep, else slow; the code also keeps it fast in pend, deep sleep and settling entered from fast.
// [R12] Slow to normal only through idle mode.
// [R13] Normal to slow directly with one mode register write.
// [R14] Writing 3 to the mode register selects slow mode.
// [R15] Light sleep enters fast or slow variant; watchdog resumes on wake.
// [R16] Deep sleep enters fast or slow variant by current mode.
// [R17] Up to three instructions may run after a standby write before halting.
// [R18] Maskable interrupt below the mask level does not wake the device.
// [R19] Interrupt flag clears take effect only with the write enable bit set.
// [R20] Mode codes: normal 0, idle 1, slow 3, light sleep 4, deep sleep 8.
package spm_pkg;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_IDLE = 4'h1;
  localparam logic [3:0] MODE_SLOW = 4'h3;
  localparam logic [3:0] MODE_LIGHT = 4'h4;
  localparam logic [3:0] MODE_DEEP = 4'h8;
  localparam int CLK_HZ = 10000000;
  // Oscillator settling time in microseconds and its cycle count, SETTLE_US times the clock in MHz.
  localparam int SETTLE_US = 6700;
  localparam int SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1000000) + 0);
  localparam logic [2:0] HALT_DELAY = 3'h3;
  localparam int NSRC = 8;
  typedef enum logic [2:0] {
    SPM_NORMAL, SPM_SLOW, SPM_IDLE, SPM_PEND, SPM_LIGHT, SPM_DEEP, SPM_SETTLE
  } spm_state_e;
endpackage

// ---- src/spm_wake_if.sv ----
`timescale 1ns/1ps
interface spm_wake_if;
  logic wake;
  modport arb (output wake);
  modport ctl (input wake);
endinterface

// ---- src/spm_wake_arb.sv ----
`timescale 1ns/1ps
module spm_wake_arb
  import spm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [NSRC-1:0] irqSet,
  input wire logic [NSRC-1:0] irqEnable,
  input wire logic [NSRC*3-1:0] irqLevel,
  input wire logic [NSRC-1:0] flagClear,
  input wire logic irqFlagWriteEnable,
  input wire logic maskableIrqGlobalEnable,
  input wire logic [2:0] interruptMaskLevel,
  output logic [NSRC-1:0] irqRequest,
  spm_wake_if.arb w
);
  logic [NSRC-1:0] next_irqRequest;
  logic [NSRC-1:0] accept;
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      // Set wins over a simultaneous clear so no event is lost.
      assign next_irqRequest[i] = irqSet[i] |
        (irqRequest[i] & ~(flagClear[i] & irqFlagWriteEnable)); // R19
      // Lower number means higher priority; level must not be below the mask.
      assign accept[i] = irqRequest[i] & irqEnable[i] &
        (irqLevel[i*3 +: 3] <= interruptMaskLevel); // R18
    end
  endgenerate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqRequest <= '0;
    end else begin
      irqRequest <= next_irqRequest;
    end
  end
  assign w.wake = maskableIrqGlobalEnable & (|accept);
endmodule

// ---- verif/spm_ctrl_asserts.sv ----
`timescale 1ns/1ps
module spm_ctrl_asserts
  import spm_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic modeWrite,
  input wire logic [3:0] modeWriteData,
  input wire logic nmiRequest,
  input wire logic irqFlagWriteEnable,
  input wire logic [3:0] operatingModeRegister,
  input wire logic [NSRC-1:0] irqRequest,
  input wire logic cpuRun,
  input wire logic fastOscEnable,
  input wire logic slowOscEnable,
  input wire logic systemClockFast,
  input wire logic watchdogRun,
  input wire logic settling
);
  logic [3:0] m;
  logic rest;
  assign m = operatingModeRegister;
  // Halted with no settling wait running, so only a standby state fits.
  assign rest = !cpuRun && !settling;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  light_osc_a: assert property (rest && m == MODE_LIGHT |-> slowOscEnable && fastOscEnable == systemClockFast)
    else $error("light sleep oscillators wrong");
  deep_osc_a: assert property (rest && m == MODE_DEEP |-> !fastOscEnable && !slowOscEnable)
    else $error("deep sleep oscillators running");
  slow_clock_a: assert property (cpuRun && m == MODE_SLOW |-> !fastOscEnable && !systemClockFast)
    else $error("slow mode clock wrong");
  idle_clock_a: assert property (m == MODE_IDLE |-> cpuRun && fastOscEnable && !systemClockFast)
    else $error("idle mode clock wrong");
  norm_clock_a: assert property (cpuRun && m == MODE_NORMAL |-> fastOscEnable && systemClockFast)
    else $error("normal mode clock wrong");
  no_direct_a: assert property (m == MODE_SLOW |=> m != MODE_NORMAL)
    else $error("slow went straight to normal");
  slow_write_a: assert property (cpuRun && m == MODE_NORMAL && modeWrite && modeWriteData == MODE_SLOW |=> m == MODE_SLOW)
    else $error("slow write not taken");
  light_wake_a: assert property (rest && m == MODE_LIGHT && nmiRequest |-> ##[1:4] cpuRun && !settling)
    else $error("light sleep wake late");
  deep_wake_a: assert property (rest && m == MODE_DEEP && nmiRequest |-> ##[1:4] settling)
    else $error("deep sleep wake without settling");
  deep_resume_a: assert property ($fell(settling) |-> cpuRun && (m == MODE_NORMAL || m == MODE_SLOW))
    else $error("settling end without resume");
  flag_hold_a: assert property (!irqFlagWriteEnable |=> (irqRequest & $past(irqRequest)) == $past(irqRequest))
    else $error("flag cleared without write enable");
  watchdog_a: assert property (watchdogRun == cpuRun)
    else $error("watchdog run mismatch");
  cover property (rest && m == MODE_LIGHT ##1 cpuRun);
  cover property ($fell(settling) && m == MODE_SLOW);
  cover property (m == MODE_IDLE ##1 m == MODE_NORMAL);
endmodule
bind spm_ctrl spm_ctrl_asserts #(.SETTLE_COUNT(SETTLE_COUNT)) u_spm_ctrl_asserts (.*);

// ---- verif/spm_ctrl_tb.sv ----
`timescale 1ns/1ps
module spm_ctrl_tb
  import spm_pkg::*;
;
  logic sys_clk = 0;
  logic rstn = 0;
  logic modeWrite = 0;
  logic instrRetire = 0;
  logic nmiRequest = 0;
  logic irqFlagWriteEnable = 0;
  logic maskableIrqGlobalEnable = 0;
  logic [3:0] modeWriteData = 4'h0;
  logic [2:0] interruptMaskLevel = 3'h0;
  logic [7:0] irqSet = 8'h00;
  logic [7:0] irqEnable = 8'hFF;
  logic [7:0] flagClear = 8'h00;
  logic [23:0] irqLevel = 24'h000000;
  logic [3:0] operatingModeRegister;
  logic [7:0] irqRequest;
  logic cpuRun, fastOscEnable, slowOscEnable, systemClockFast, watchdogRun, settling;
  logic [3:0] st;
  int errors = 0;
  int checked = 0;
  assign st = {cpuRun, fastOscEnable, slowOscEnable, systemClockFast};
  spm_ctrl #(.SETTLE_COUNT(10)) u_spm_ctrl (.*);
  initial forever #50 sys_clk = ~sys_clk;
  // Expected run, fast osc, slow osc, fast clock and mode code.
  function automatic logic [7:0] ex(logic [3:0] m, logic f);
    if (m == MODE_DEEP) return {3'h0, f, m};
    if (m == MODE_IDLE) return {4'hE, m};
    return {m != MODE_LIGHT, f, 1'b1, f, m};
  endfunction
  function automatic logic ok(logic [2:0] l, logic [2:0] k, logic g);
    return g && l <= k;
  endfunction
  task automatic conclude;
    $display("Counts: %0d mismatches in %0d checks", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic waitRun(input logic v, input int n);
    while (cpuRun !== v && n > 0) begin
      tick(1);
      n--;
    end
    if (cpuRun !== v) begin
      errors++;
      $display("ERROR %0t: run state wait expired", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] d);
    tick(1);
    modeWrite = 1;
    modeWriteData = d;
    tick(1);
    modeWrite = 0;
  endtask
  task automatic retire(input int n);
    repeat (n) begin
      tick(1);
      instrRetire = 1;
      tick(1);
      instrRetire = 0;
    end
  endtask
  task automatic clr;
    tick(1);
    irqFlagWriteEnable = 1;
    flagClear = 8'hFF;
    tick(1);
    flagClear = 8'h00;
    irqFlagWriteEnable = 0;
  endtask
  task automatic sl(input logic [3:0] d, input logic f);
    wr(d);
    retire(2);
    tick(2);
    chk({st[3], 3'h0, operatingModeRegister}, {4'h8, d});
    retire(1);
    waitRun(0, 6);
    chk({st, operatingModeRegister}, ex(d, f));
    chk({7'h0, watchdogRun}, 8'h00);
  endtask
  task automatic wk(input logic [3:0] d, input logic f);
    tick(1);
    nmiRequest = 1;
    waitRun(1, 40);
    nmiRequest = 0;
    chk({st, operatingModeRegister}, ex(d, f));
    chk({7'h0, watchdogRun}, 8'h01);
  endtask
  initial begin
    logic [2:0] lvl, msk;
    logic gie, we, both;
    logic [7:0] c, f, e;
    int src;
    void'($urandom(50962));
    tick(16);
    chk({6'h0, settling, cpuRun}, 8'h02);
    rstn = 1;
    tick(100);
    chk({6'h0, settling, cpuRun}, 8'h02);
    waitRun(1, 70000);
    chk({st, operatingModeRegister}, ex(MODE_NORMAL, 1));
    clr();
    e = 8'h00;
    for (int i = 0; i < 8; i++) begin
      f = 8'($urandom);
      c = (i == 0) ? 8'hFF : 8'($urandom);
      we = (i != 0) & 1'($urandom);
      // Some rounds clear in the same cycle as the set, where the set must win.
      both = (i == 1) | 1'($urandom);
      tick(1);
      irqSet = f;
      irqFlagWriteEnable = we & both;
      flagClear = both ? c : 8'h00;
      tick(1);
      irqSet = 8'h00;
      irqFlagWriteEnable = we & !both;
      flagClear = both ? 8'h00 : c;
      tick(1);
      flagClear = 8'h00;
      irqFlagWriteEnable = 0;
      tick(1);
      e = both ? (f | (we ? e & ~c : e)) : (we ? (e | f) & ~c : e | f);
      chk(irqRequest, e);
    end
    $display("Test reset and flags done");
    for (int i = 0; i < 12; i++) begin
      lvl = (i == 0) ? 3'h5 : (i == 1) ? 3'h6 : 3'($urandom);
      msk = (i < 2) ? 3'h5 : 3'($urandom);
      gie = (i < 2) | 1'($urandom);
      clr();
      maskableIrqGlobalEnable = gie;
      interruptMaskLevel = msk;
      irqLevel = {8{lvl}};
      irqEnable = (i < 2) ? 8'hFF : 8'($urandom);
      if (cpuRun === 1'b1) sl(MODE_LIGHT, 1);
      src = $urandom % 8;
      irqSet[src] = 1;
      tick(1);
      irqSet = 8'h00;
      tick(3);
      chk({st, operatingModeRegister}, ex(ok(lvl, msk, gie & irqEnable[src]) ? MODE_NORMAL : MODE_LIGHT, 1));
    end
    wk(MODE_NORMAL, 1);
    $display("Test light sleep done");
    wr(MODE_SLOW);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_SLOW, 0));
    wr(MODE_NORMAL);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_SLOW, 0));
    clr();
    sl(MODE_LIGHT, 0);
    wk(MODE_SLOW, 0);
    sl(MODE_DEEP, 0);
    nmiRequest = 1;
    tick(5);
    chk({7'h0, settling}, 8'h01);
    wk(MODE_SLOW, 0);
    wr(MODE_IDLE);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_IDLE, 0));
    wr(MODE_SLOW);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_SLOW, 0));
    wr(MODE_IDLE);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_IDLE, 0));
    wr(MODE_NORMAL);
    tick(1);
    chk({st, operatingModeRegister}, ex(MODE_NORMAL, 1));
    $display("Test slow and idle done");
    maskableIrqGlobalEnable = 1;
    interruptMaskLevel = 3'h7;
    irqEnable = 8'hFF;
    clr();
    sl(MODE_DEEP, 1);
    irqSet = 8'h80;
    tick(1);
    irqSet = 8'h00;
    tick(4);
    chk({7'h0, settling}, 8'h01);
    waitRun(1, 40);
    chk({st, operatingModeRegister}, ex(MODE_NORMAL, 1));
    $display("Test deep sleep done");
    conclude();
  end
endmodule
